// file: hdl/iox_core.sv
// Notes on behaviour
// - reset initialises every register and the bus state machine
// - input pins have both drivers off, pin floats
// - output pins driven high or low from stored output bit
// - any edge on an input pin raises the alert
// - alert drops when inputs return to their earlier levels
// - reading a port clears its alert at rising SCL of ack bit
// - new changes after a clear raise the alert again
// - output pins never touch the alert; foreign bus traffic only in the pointer 00h case
// - switching output to input may raise a false alert
// - alert tracked per 8-pin port; reads clear only their port
// - alert is open-drain active low, pulls down only
// - pointer 00h plus foreign read address clears the port 0 alert at rising SCL of the R/W bit
// - general call address ignored and not acknowledged
// - matching address acknowledged low through ack high phase
// - SDA changes only while SCL low; else start or stop
// - eight bits then one ack; transmitter releases SDA first
// - every written byte is acknowledged
// - master nack ends a read; device releases SDA
// - direction bit 1 makes an input, 0 an output
// - command byte selects one of eight registers 0 to 7
`timescale 1ns/100ps
module iox_core
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic [2:0]  addr_select_pins,
  input  wire logic [15:0] port_in,
  output logic      [15:0] port_out,
  output logic      [15:0] port_oe,
  output logic             alert_n_out,
  output logic             alert_n_oe
);

  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_ADDR = 6'b00_0010,
    ST_AACK = 6'b00_0100,
    ST_WRX  = 6'b00_1000,
    ST_TX   = 6'b01_0000,
    ST_MACK = 6'b10_0000
  } iox_state_t;

  iox_state_t              state_r;
  iox_pkg::iox_bus_t       bus_m_r;
  iox_pkg::iox_bus_t       bus_s_r;
  iox_pkg::iox_bus_t       bus_d_r;
  logic [15:0]             pin_m_r;
  logic [15:0]             pin_s_r;
  iox_pkg::iox_port_regs_t regs_r [2];
  logic [7:0]              cmd_r;
  logic [7:0]              shift_r;
  logic [3:0]              bitcnt_r;
  logic                    first_r;
  logic                    rd_r;
  logic                    acking_r;
  logic                    mine_r;
  logic [15:0]             snap_r;
  logic                    drive_low_r;
  logic [15:0]             in_eff;
  logic [1:0]              alert_src;
  logic [7:0]              rd_byte;
  wire  [15:0]             cfg_all  = {regs_r[1].cfg, regs_r[0].cfg};
  wire  [15:0]             outv_all = {regs_r[1].outv, regs_r[0].outv};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // edges from the synchronised bus samples, never the first flop
  wire scl_rise = bus_s_r.scl & ~bus_d_r.scl;
  wire scl_fall = ~bus_s_r.scl & bus_d_r.scl;
  wire start_c  = bus_s_r.scl & bus_d_r.scl & ~bus_s_r.sda & bus_d_r.sda;
  wire stop_c   = bus_s_r.scl & bus_d_r.scl & bus_s_r.sda & ~bus_d_r.sda;
  wire [7:0] rx_byte = {shift_r[6:0], bus_s_r.sda};

  function automatic logic [7:0] reg_read(input logic [2:0] p,
                                          input logic [15:0] inp);
    iox_pkg::iox_port_regs_t r;
    r = regs_r[p[0]];
    case (p[2:1])
      2'd0:    reg_read = p[0] ? inp[15:8] : inp[7:0];
      2'd1:    reg_read = r.outv;
      2'd2:    reg_read = r.pol;
      default: reg_read = r.cfg;
    endcase
  endfunction

  // byte under the pointer, read out bit by bit during a read
  always_comb
  begin
    rd_byte = reg_read(cmd_r[2:0], in_eff);
  end

  // two-flop synchronisers for bus and port pins
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bus_m_r <= '1;
      bus_s_r <= '1;
      bus_d_r <= '1;
      pin_m_r <= '0;
      pin_s_r <= '0;
    end
    else
    begin
      bus_m_r <= {scl_in, sda_in};
      bus_s_r <= bus_m_r;
      bus_d_r <= bus_s_r;
      pin_m_r <= port_in;
      pin_s_r <= pin_m_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_port
      // input register value with polarity inversion applied
      assign in_eff[g*8 +: 8] = pin_s_r[g*8 +: 8] ^ regs_r[g].pol;
      // only input-configured bits compare against the snapshot
      assign alert_src[g] = |((pin_s_r[g*8 +: 8] ^ snap_r[g*8 +: 8])
                              & regs_r[g].cfg);
    end
  endgenerate

  // byte-level slave state machine
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r  <= ST_IDLE;
      shift_r  <= '0;
      bitcnt_r <= '0;
      first_r  <= 1'b0;
      rd_r     <= 1'b0;
      acking_r <= 1'b0;
      mine_r   <= 1'b0;
    end
    else if (start_c)
    begin
      state_r  <= ST_ADDR;
      bitcnt_r <= '0;
      mine_r   <= 1'b0;
    end
    else if (stop_c)
    begin
      state_r <= ST_IDLE;
      mine_r  <= 1'b0;
    end
    else if (scl_rise)
    begin
      case (state_r)
        ST_ADDR, ST_WRX:
        begin
          shift_r  <= rx_byte;
          bitcnt_r <= bitcnt_r + 4'd1;
          if (bitcnt_r == 4'(iox_pkg::BYTE_BITS - 1))
          begin
            if (state_r == ST_ADDR)
            begin
              rd_r     <= bus_s_r.sda;
              acking_r <= (rx_byte[7:1] ==
                           (iox_pkg::DEV_ADDR_BASE | 7'(addr_select_pins)))
                          && (rx_byte[7:1] != iox_pkg::GEN_CALL_ADDR);
              first_r  <= 1'b1;
            end
            else
              acking_r <= 1'b1;
          end
        end
        ST_TX:
          bitcnt_r <= bitcnt_r + 4'd1;
        ST_MACK:
          // master nack ends the read and we let go of SDA
          if (bus_s_r.sda)
            state_r <= ST_IDLE;
        default:
          state_r <= state_r;
      endcase
    end
    else if (scl_fall)
    begin
      case (state_r)
        ST_ADDR:
          if (bitcnt_r == 4'(iox_pkg::BYTE_BITS))
          begin
            bitcnt_r <= '0;
            if (acking_r)
            begin
              state_r <= ST_AACK;
              mine_r  <= 1'b1;
            end
            else
              state_r <= ST_IDLE;
          end
        ST_WRX:
          if (bitcnt_r == 4'(iox_pkg::BYTE_BITS))
          begin
            bitcnt_r <= '0;
            state_r  <= ST_AACK;
            // only the first byte after the address is the pointer
            first_r  <= 1'b0;
          end
        ST_AACK:
        begin
          acking_r <= 1'b0;
          bitcnt_r <= '0;
          state_r  <= rd_r ? ST_TX : ST_WRX;
        end
        ST_TX:
          if (bitcnt_r == 4'(iox_pkg::BYTE_BITS))
            state_r <= ST_MACK;
        ST_MACK:
        begin
          bitcnt_r <= '0;
          state_r  <= ST_TX;
        end
        default:
          state_r <= state_r;
      endcase
    end
  end

  // register file, command pointer with pair toggling
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cmd_r <= iox_pkg::RST_CMD;
      for (int i = 0; i < 2; i++)
        regs_r[i] <= {iox_pkg::RST_OUT, iox_pkg::RST_POL, iox_pkg::RST_CFG};
    end
    else if (scl_fall && state_r == ST_WRX &&
             bitcnt_r == 4'(iox_pkg::BYTE_BITS))
    begin
      if (first_r)
        cmd_r <= shift_r;
      else
      begin
        case (cmd_r[2:1])
          2'd1: regs_r[cmd_r[0]].outv <= shift_r;
          2'd2: regs_r[cmd_r[0]].pol  <= shift_r;
          2'd3: regs_r[cmd_r[0]].cfg  <= shift_r;
          default: regs_r[cmd_r[0]].outv <= regs_r[cmd_r[0]].outv;
        endcase
        cmd_r[0] <= ~cmd_r[0];
      end
    end
    else if (scl_fall && state_r == ST_MACK)
      cmd_r[0] <= ~cmd_r[0];
  end

  sda_stable_a: assert property
    (bus_s_r.scl && bus_d_r.scl |=> $stable(drive_low_r))
    else $error("sda drive changed while scl high");
  ack_hold_a: assert property
    (state_r == ST_AACK && scl_rise |-> drive_low_r)
    else $error("ack not held low");
  gen_call_a: assert property
    (scl_fall && state_r == ST_ADDR && bitcnt_r == 4'(iox_pkg::BYTE_BITS)
     && shift_r[7:1] == iox_pkg::GEN_CALL_ADDR |=> !drive_low_r)
    else $error("general call acknowledged");
  read_done_c: cover property (state_r == ST_MACK && scl_rise && bus_s_r.sda);

  // sda drive: ack low, read data, released otherwise
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      drive_low_r <= 1'b0;
    else if (scl_fall)
    begin
      if ((state_r == ST_ADDR || state_r == ST_WRX) &&
          bitcnt_r == 4'(iox_pkg::BYTE_BITS))
        drive_low_r <= acking_r || (state_r == ST_ADDR &&
                       (shift_r[7:1] ==
                        (iox_pkg::DEV_ADDR_BASE | 7'(addr_select_pins)))
                       && shift_r[7:1] != iox_pkg::GEN_CALL_ADDR);
      else if (state_r == ST_AACK && rd_r)
        drive_low_r <= ~rd_byte[7];
      else if (state_r == ST_MACK)
        drive_low_r <= ~rd_byte[7];
      else if (state_r == ST_TX && bitcnt_r < 4'(iox_pkg::BYTE_BITS))
        // first fall of a byte follows bit 7, so bit 7 - count goes next
        drive_low_r <= ~rd_byte[3'd7 - bitcnt_r[2:0]];
      else
        drive_low_r <= 1'b0;
    end
    else if (start_c || stop_c)
      drive_low_r <= 1'b0;
  end

  // alert snapshot: a read of a port reloads only that port's snapshot
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      snap_r <= '0;
    else if (scl_rise && state_r == ST_MACK && !cmd_r[2] && !cmd_r[1])
      snap_r[cmd_r[0]*8 +: 8] <= pin_s_r[cmd_r[0]*8 +: 8];
    else if (scl_rise && state_r == ST_ADDR && !mine_r &&
             bitcnt_r == 4'(iox_pkg::BYTE_BITS - 1) && bus_s_r.sda &&
             cmd_r == iox_pkg::CMD_ERRATA)
      // foreign read address with pointer 00h reloads port 0 snapshot
      snap_r[7:0] <= pin_s_r[7:0];
  end

  // outputs straight from flops; alert only ever pulls low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      port_out    <= '0;
      port_oe     <= '0;
      sda_out     <= 1'b0;
      sda_oe      <= 1'b0;
      alert_n_out <= 1'b0;
      alert_n_oe  <= 1'b0;
    end
    else
    begin
      port_out <= {regs_r[1].outv, regs_r[0].outv};
      port_oe  <= ~{regs_r[1].cfg, regs_r[0].cfg};
      sda_oe   <= drive_low_r;
      alert_n_oe <= |alert_src;
    end
  end

  in_float_a: assert property
    (1'b1 |=> (port_oe & $past(cfg_all)) == 16'h0000)
    else $error("input pin driven");
  out_level_a: assert property
    (1'b1 |=> ((port_out ^ $past(outv_all)) & port_oe) == 16'h0000)
    else $error("output pin level wrong");
  alert_raise_a: assert property
    ((|alert_src) |=> alert_n_oe)
    else $error("alert not raised");
  alert_quiet_a: assert property
    (!(|alert_src) |=> !alert_n_oe)
    else $error("alert without source");
  alert_drain_a: assert property
    (alert_n_out == 1'b0)
    else $error("alert pin driven high");
  alert_seen_c: cover property (alert_n_oe);
  reg_write_c: cover property (scl_fall && state_r == ST_WRX && !first_r);

endmodule

// file: pkg/iox_pkg.sv
package iox_pkg;

  localparam logic [6:0] DEV_ADDR_BASE = 7'h20;
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
  localparam logic [2:0] PTR_IN0  = 3'h0;
  localparam logic [2:0] PTR_IN1  = 3'h1;
  localparam logic [2:0] PTR_OUT0 = 3'h2;
  localparam logic [2:0] PTR_OUT1 = 3'h3;
  localparam logic [2:0] PTR_POL0 = 3'h4;
  localparam logic [2:0] PTR_POL1 = 3'h5;
  localparam logic [2:0] PTR_CFG0 = 3'h6;
  localparam logic [2:0] PTR_CFG1 = 3'h7;
  localparam logic [7:0] CMD_ERRATA = 8'h00;
  localparam logic [7:0] RST_OUT  = 8'hFF;
  localparam logic [7:0] RST_POL  = 8'h00;
  localparam logic [7:0] RST_CFG  = 8'hFF;
  localparam logic [7:0] RST_CMD  = 8'h00;
  localparam int         BYTE_BITS = 8;

  typedef struct packed {
    logic [7:0] outv;
    logic [7:0] pol;
    logic [7:0] cfg;
  } iox_port_regs_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } iox_bus_t;

endpackage

// file: verification/iox_i2c_master.sv
`timescale 1ns/100ps
module iox_i2c_master
(
  input  wire logic clk,
  input  wire logic sda_in,
  output logic      scl_o,
  output logic      sda_o
);
  // open-drain master: a 1 releases the line and the pull-up makes it high
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // long wait before scl rises: the slave may still hold its ack low
  task automatic start();
    sda_o = 1'b1;
    w(6);
    scl_o = 1'b1;
    w(3);
    sda_o = 1'b0;
    w(3);
    scl_o = 1'b0;
  endtask

  task automatic stop();
    sda_o = 1'b0;
    w(6);
    scl_o = 1'b1;
    w(3);
    sda_o = 1'b1;
    w(3);
  endtask

  // 6 cycles low, 2 high: 200 ns per bit, sda moves only while scl low
  task automatic xfer(input logic b, output logic s);
    w(3);
    sda_o = b;
    w(3);
    scl_o = 1'b1;
    w(1);
    s = sda_in;
    w(1);
    scl_o = 1'b0;
  endtask

  task automatic wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      xfer(d[i], s);
    xfer(1'b1, s);
    ack = ~s;
  endtask

  task automatic rd(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      xfer(1'b1, s);
      d[i] = s;
    end
    xfer(last, s);
  endtask
endmodule

// file: verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  localparam logic [2:0] SEL = 3'h5;
  logic        clk = 1'b0;
  logic        rst;
  logic        scl_m;
  logic        sda_m;
  logic        sda_bus;
  logic        sda_out;
  logic        sda_oe;
  logic        alert_n_out;
  logic        alert_n_oe;
  logic        alert_line;
  logic [6:0]  dev;
  logic [15:0] ext_in;
  logic [15:0] port_in;
  logic [15:0] port_out;
  logic [15:0] port_oe;
  int          failures = 0;
  int          check_count = 0;
  int          cycles = 0;

  assign dev        = iox_pkg::DEV_ADDR_BASE | {4'h0, SEL};
  assign sda_bus    = sda_m & ~(sda_oe & ~sda_out);
  assign alert_line = ~(alert_n_oe & ~alert_n_out);
  // a driven pin reads back its own level, a floating one the board's
  assign port_in    = (port_oe & port_out) | (~port_oe & ext_in);

  always #12.5 clk = ~clk;

  iox_i2c_master m_u
  (
    .clk    (clk),
    .sda_in (sda_bus),
    .scl_o  (scl_m),
    .sda_o  (sda_m)
  );

  iox_core dut_u
  (
    .clk              (clk),
    .rst              (rst),
    .scl_in           (scl_m),
    .sda_in           (sda_bus),
    .sda_out          (sda_out),
    .sda_oe           (sda_oe),
    .addr_select_pins (SEL),
    .port_in          (port_in),
    .port_out         (port_out),
    .port_oe          (port_oe),
    .alert_n_out      (alert_n_out),
    .alert_n_oe       (alert_n_oe)
  );

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string msg);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic send(input logic [7:0] d, input logic exp_ack);
    logic a;
    m_u.wr(d, a);
    chk(16'(a), 16'(exp_ack), "acknowledge");
  endtask

  task automatic reg_wr(input logic [2:0] p, input logic [7:0] d0,
                        input logic [7:0] d1);
    m_u.start();
    send({dev, 1'b0}, 1'b1);
    send({5'h00, p}, 1'b1);
    send(d0, 1'b1);
    send(d1, 1'b1);
    m_u.stop();
  endtask

  task automatic reg_rd(input logic [2:0] p, input logic [7:0] exp);
    logic [7:0] d;
    m_u.start();
    send({dev, 1'b0}, 1'b1);
    send({5'h00, p}, 1'b1);
    m_u.start();
    send({dev, 1'b1}, 1'b1);
    m_u.rd(1'b1, d);
    m_u.stop();
    chk(16'(d), 16'(exp), "input port value");
  endtask

  // bounded poll: the alert path has a few synchroniser stages
  task automatic wait_alert(input logic exp, input string msg);
    for (int i = 0; i < 40 && alert_line !== exp; i++)
      @(posedge clk);
    chk(16'(alert_line), 16'(exp), msg);
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      end_of_test();
    end
  end

  initial
  begin
    rst    = 1'b1;
    ext_in = 16'h0000;
    m_u.w(12);
    rst = 1'b0;
    m_u.w(4);
    chk(port_oe, 16'h0000, "pins float after reset");
    chk(16'(alert_line), 16'h0001, "alert released");
    $display("test reset done");
    m_u.start();
    send(8'h00, 1'b0);
    m_u.stop();
    m_u.start();
    send({iox_pkg::DEV_ADDR_BASE, 1'b1}, 1'b0);
    m_u.stop();
    $display("test address filter done");
    reg_wr(iox_pkg::PTR_CFG0, 8'hF0, 8'h0F);
    reg_wr(iox_pkg::PTR_OUT0, 8'hA5, 8'h3C);
    m_u.w(10);
    chk(port_oe, 16'hF00F, "direction");
    chk(port_out & port_oe, 16'h3005, "output levels");
    wait_alert(1'b1, "outputs never alert");
    $display("test port write done");
    ext_in[9] = 1'b1;
    wait_alert(1'b0, "edge raises alert");
    ext_in[9] = 1'b0;
    wait_alert(1'b1, "return drops alert");
    ext_in[9] = 1'b1;
    wait_alert(1'b0, "edge raises alert");
    reg_rd(iox_pkg::PTR_IN0, 8'h05);
    m_u.w(10);
    chk(16'(alert_line), 16'h0000, "other port keeps alert");
    reg_rd(iox_pkg::PTR_IN1, 8'h32);
    wait_alert(1'b1, "read clears alert");
    ext_in[9] = 1'b0;
    wait_alert(1'b0, "new change alerts");
    reg_rd(iox_pkg::PTR_IN1, 8'h30);
    wait_alert(1'b1, "read clears alert");
    reg_wr(iox_pkg::PTR_OUT0, 8'hA5, 8'h3C);
    $display("test alert done");
    end_of_test();
  end
endmodule
